// *** common/cbas_pkg.sv ***
package cbas_pkg;
   // ****************************************
   // attribute sources
   // ****************************************
   typedef enum logic [1:0] {
      CBAS_SRC_BASE = 2'h0,
      CBAS_SRC_DIR = 2'h1,
      CBAS_SRC_TBL = 2'h2
   } cbas_src_t;
   // ****************************************
   // management sequencer
   // ****************************************
   typedef enum logic [1:0] {
      CBAS_MG_IDLE = 2'h0,
      CBAS_MG_DRAIN = 2'h1,
      CBAS_MG_ACTIVE = 2'h2,
      CBAS_MG_EXIT = 2'h3
   } cbas_mg_t;
   localparam logic [31:0] CBAS_RESET_FETCH = 32'hFFFFFFF0;
   localparam logic [31:0] CBAS_MGMT_BASE = 32'h00038000;
   localparam int CBAS_MGMT_REQ_LEAD = 3;
   localparam int CBAS_WARM_RESET_CLKS = 15;
   localparam int CBAS_DATA_BYTES = 8;
endpackage

// *** src/cbas_core.sv ***
// Overview of operation
// - page cache-disable high marks the page uncacheable, else caching follows other signals
// - real mode or paging off: cache-disable output equals control register zero bit
// - paging on: cache-disable is control bit ORed with page base, directory or table entry by access kind
// - write-through output zero without paging, else from base, directory or table
// - attributes driven with address strobe, held until next-address or last burst-ready
// - attributes and split output float on back-off or hold acknowledge
// - even parity checked per enabled byte on reads
// - parity error only for memory, I/O reads and second interrupt acknowledge
// - parity error low one clock, one edge after the failing burst-ready
// - no internal exception on parity error; system reacts
// - reset clears all state except the test-mode latch, output-enable register and reset sample register, and sets fetch address
// - reset sampled as a level every clock edge
// - cache-flush sampled at reset fall selects three-state test mode
// - split output asserted for misaligned locked transfers
// - split output set with strobe, cleared at end of locked sequence
// - management entry drains cycles, acknowledges after buffer empty, jumps to base
// - management request latched on falling edge, acted on at boundary
// - request during management mode is held until service exits
// - active output after pending cycles and buffer empty, held until exit done
module cbas_core (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic address_strobe_n_i,
   input wire logic next_address_in_n_i,
   input wire logic burst_ready_in_n_i,
   input wire logic last_ready_i,
   input wire logic back_off_in_n_i,
   input wire logic bus_grant_ack_out_i,
   input wire logic real_mode_i,
   input wire logic cache_disable_bit_i,
   input wire logic paging_enable_bit_i,
   input wire logic [1:0] page_base_reg_i,
   input wire logic [1:0] dir_entry_attr_i,
   input wire logic [1:0] tbl_entry_attr_i,
   input wire logic [1:0] attr_src_i,
   input wire logic locked_i,
   input wire logic [3:0] xfer_size_i,
   input wire logic [2:0] addr_low_i,
   input wire logic cyc_read_i,
   input wire logic cyc_check_i,
   input wire logic [63:0] data_i,
   input wire logic [7:0] data_par_i,
   input wire logic [7:0] byte_enables_n_i,
   input wire logic cache_flush_n_i,
   input wire logic mgmt_interrupt_in_n_i,
   input wire logic bus_idle_i,
   input wire logic ext_write_buffer_empty_n_i,
   input wire logic wbe_mask_i,
   input wire logic boundary_i,
   input wire logic mgmt_exit_i,
   output logic page_cache_disable_out_o,
   output logic page_cache_disable_oe_n_o,
   output logic page_write_through_out_o,
   output logic page_write_through_oe_n_o,
   output logic split_cycle_out_o,
   output logic split_cycle_oe_n_o,
   output logic parity_error_out_n_o,
   output logic parity_error_oe_n_o,
   output logic mgmt_active_out_n_o,
   output logic test_mode_o,
   output logic [31:0] fetch_addr_o,
   output logic mgmt_enter_o
);
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic misaligned(input logic [3:0] sz, input logic [2:0] a);
      logic r;
      r = 1'b0;
      unique case (sz)
         4'h2: r = (a[1:0] == 2'h3);
         4'h4: r = (a[1:0] != 2'h0);
         4'h8: r = (a != 3'h0);
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   logic cdis_q, cdis_d, wthru_q, wthru_d, split_q, split_d, fl_q, fl_d;
   logic perr_n_q, perr_n_d, tst_q, tst_d, rst_q, rst_d, oe_n_q, oe_n_d;
   logic req_prev_q, req_prev_d, req_pend_q, req_pend_d, act_n_q, act_n_d, ent_q, ent_d;
   logic [31:0] fa_q, fa_d;
   cbas_pkg::cbas_mg_t mg_q, mg_d;
   logic strobe, ends, bad, src_cdis, src_wthru;

   // ****************************************
   // attributes, split, parity, reset, management
   // ****************************************
   always_comb begin
      strobe = !address_strobe_n_i;
      ends = !next_address_in_n_i || (!burst_ready_in_n_i && last_ready_i);
      unique case (cbas_pkg::cbas_src_t'(attr_src_i))
         cbas_pkg::CBAS_SRC_DIR: begin
            src_cdis = dir_entry_attr_i[1];
            src_wthru = dir_entry_attr_i[0];
         end
         cbas_pkg::CBAS_SRC_TBL: begin
            src_cdis = tbl_entry_attr_i[1];
            src_wthru = tbl_entry_attr_i[0];
         end
         default: begin
            src_cdis = page_base_reg_i[1];
            src_wthru = page_base_reg_i[0];
         end
      endcase
      cdis_d = cdis_q;
      wthru_d = wthru_q;
      split_d = split_q;
      fl_d = fl_q;
      if (strobe) begin
         if (real_mode_i || !paging_enable_bit_i) begin
            cdis_d = cache_disable_bit_i;
            wthru_d = 1'b0;
         end else begin
            cdis_d = cache_disable_bit_i | src_cdis;
            wthru_d = src_wthru;
         end
         if (locked_i && misaligned(xfer_size_i, addr_low_i)) begin
            split_d = 1'b1;
         end
         fl_d = 1'b0;
      end else if (ends) begin
         cdis_d = 1'b0;
         wthru_d = 1'b0;
         if (!locked_i) begin
            split_d = 1'b0;
         end
      end
      if (!back_off_in_n_i || bus_grant_ack_out_i) begin
         fl_d = 1'b1;
      end
      bad = 1'b0;
      for (int i = 0; i < cbas_pkg::CBAS_DATA_BYTES; i++) begin
         if (!byte_enables_n_i[i] && ((^data_i[i*8 +: 8]) ^ data_par_i[i])) begin
            bad = 1'b1;
         end
      end
      perr_n_d = !(!burst_ready_in_n_i && cyc_read_i && cyc_check_i && bad);
      rst_d = rst_i;
      tst_d = tst_q;
      if (rst_q && !rst_i) begin
         tst_d = !cache_flush_n_i;
      end
      oe_n_d = (fl_d && !rst_i) || tst_d;
      fa_d = fa_q;
      req_prev_d = mgmt_interrupt_in_n_i;
      req_pend_d = req_pend_q;
      if (req_prev_q && !mgmt_interrupt_in_n_i) begin
         req_pend_d = 1'b1;
      end
      mg_d = mg_q;
      act_n_d = act_n_q;
      ent_d = 1'b0;
      unique case (mg_q)
         cbas_pkg::CBAS_MG_IDLE: begin
            if (req_pend_q && boundary_i) begin
               mg_d = cbas_pkg::CBAS_MG_DRAIN;
               req_pend_d = req_prev_q && !mgmt_interrupt_in_n_i;
            end
         end
         cbas_pkg::CBAS_MG_DRAIN: begin
            if (bus_idle_i && (wbe_mask_i || !ext_write_buffer_empty_n_i)) begin
               act_n_d = 1'b0;
               ent_d = 1'b1;
               fa_d = cbas_pkg::CBAS_MGMT_BASE;
               mg_d = cbas_pkg::CBAS_MG_ACTIVE;
            end
         end
         cbas_pkg::CBAS_MG_ACTIVE: begin
            if (mgmt_exit_i) begin
               mg_d = cbas_pkg::CBAS_MG_EXIT;
            end
         end
         cbas_pkg::CBAS_MG_EXIT: begin
            if (bus_idle_i) begin
               act_n_d = 1'b1;
               mg_d = cbas_pkg::CBAS_MG_IDLE;
            end
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      rst_q <= rst_d;
      if (rst_i) begin
         cdis_q <= 1'b0;
         wthru_q <= 1'b0;
         split_q <= 1'b0;
         fl_q <= 1'b0;
         perr_n_q <= 1'b1;
         req_prev_q <= 1'b1;
         req_pend_q <= 1'b0;
         act_n_q <= 1'b1;
         ent_q <= 1'b0;
         fa_q <= cbas_pkg::CBAS_RESET_FETCH;
         mg_q <= cbas_pkg::CBAS_MG_IDLE;
      end else begin
         cdis_q <= cdis_d;
         wthru_q <= wthru_d;
         split_q <= split_d;
         fl_q <= fl_d;
         perr_n_q <= perr_n_d;
         req_prev_q <= req_prev_d;
         req_pend_q <= req_pend_d;
         act_n_q <= act_n_d;
         ent_q <= ent_d;
         fa_q <= fa_d;
         mg_q <= mg_d;
      end
      tst_q <= tst_d;
      oe_n_q <= oe_n_d;
   end

   // ****************************************
   // outputs
   // ****************************************
   always_comb begin
      page_cache_disable_out_o = cdis_q;
      page_write_through_out_o = wthru_q;
      split_cycle_out_o = split_q;
      page_cache_disable_oe_n_o = oe_n_q;
      page_write_through_oe_n_o = oe_n_q;
      split_cycle_oe_n_o = oe_n_q;
      parity_error_out_n_o = perr_n_q;
      parity_error_oe_n_o = tst_q;
      mgmt_active_out_n_o = act_n_q;
      test_mode_o = tst_q;
      fetch_addr_o = fa_q;
      mgmt_enter_o = ent_q;
   end

   // ****************************************
   // checks
   // ****************************************
   a_perr_one_clk: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !parity_error_out_n_o |=> parity_error_out_n_o || !$past(perr_n_d))
      else $error("parity error too long");
   a_perr_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $fell(parity_error_out_n_o) |-> $past(!burst_ready_in_n_i && cyc_read_i))
      else $error("parity error without read ready");
   a_perr_no_check: assert property (@(posedge core_clk_i) disable iff (rst_i)
      burst_ready_in_n_i || !cyc_read_i || !cyc_check_i |=> parity_error_out_n_o)
      else $error("parity error outside checked read");
   a_float_backoff: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !back_off_in_n_i |=> page_cache_disable_oe_n_o && split_cycle_oe_n_o)
      else $error("no float on back-off");
   a_float_grant: assert property (@(posedge core_clk_i) disable iff (rst_i)
      bus_grant_ack_out_i |=> page_write_through_oe_n_o && split_cycle_oe_n_o)
      else $error("no float on hold acknowledge");
   a_wt_nopage: assert property (@(posedge core_clk_i) disable iff (rst_i)
      strobe && !paging_enable_bit_i |=> !page_write_through_out_o)
      else $error("write-through set without paging");
   a_real_cache_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
      strobe && real_mode_i |=> page_cache_disable_out_o == $past(cache_disable_bit_i))
      else $error("cache-disable not from control bit");
   a_flat_cache_bit: assert property (@(posedge core_clk_i) disable iff (rst_i)
      strobe && !real_mode_i && !paging_enable_bit_i |=> page_cache_disable_out_o == $past(cache_disable_bit_i))
      else $error("cache-disable not from control bit without paging");
   a_dir_attr: assert property (@(posedge core_clk_i) disable iff (rst_i)
      strobe && !real_mode_i && paging_enable_bit_i && attr_src_i == cbas_pkg::CBAS_SRC_DIR
      |=> page_write_through_out_o == $past(dir_entry_attr_i[0]))
      else $error("write-through not from directory entry");
   a_tbl_attr: assert property (@(posedge core_clk_i) disable iff (rst_i)
      strobe && !real_mode_i && paging_enable_bit_i && attr_src_i == cbas_pkg::CBAS_SRC_TBL
      |=> page_write_through_out_o == $past(tbl_entry_attr_i[0]))
      else $error("write-through not from table entry");
   a_attr_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !strobe && !ends |=> $stable(page_cache_disable_out_o))
      else $error("attribute changed mid cycle");
   a_attr_end: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ends && !strobe |=> !page_cache_disable_out_o && !page_write_through_out_o)
      else $error("attributes not released at cycle end");
   a_act_wbe: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $fell(mgmt_active_out_n_o) |-> $past(wbe_mask_i || !ext_write_buffer_empty_n_i))
      else $error("active before buffer empty");
   a_exit_idle: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(mgmt_active_out_n_o) |-> $past(bus_idle_i))
      else $error("active dropped before exit cycles done");
   a_entry_base: assert property (@(posedge core_clk_i) disable iff (rst_i)
      mgmt_enter_o |-> fetch_addr_o == cbas_pkg::CBAS_MGMT_BASE ##1 !mgmt_enter_o)
      else $error("bad management entry");
   a_split_mis: assert property (@(posedge core_clk_i) disable iff (rst_i)
      strobe && locked_i && xfer_size_i == 4'h8 && addr_low_i != 3'h0 |=> split_cycle_out_o)
      else $error("split not flagged");
   a_split_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
      ends && !strobe && !locked_i |=> !split_cycle_out_o)
      else $error("split not cleared at sequence end");
   a_reset_state: assert property (@(posedge core_clk_i)
      rst_i |=> mgmt_active_out_n_o && parity_error_out_n_o && fetch_addr_o == cbas_pkg::CBAS_RESET_FETCH)
      else $error("state not initialised by reset");

   // ****************************************
   // coverage
   // ****************************************
   c_perr: cover property (@(posedge core_clk_i) !parity_error_out_n_o);
   c_mgmt: cover property (@(posedge core_clk_i) $fell(mgmt_active_out_n_o));
   c_exit: cover property (@(posedge core_clk_i) $rose(mgmt_active_out_n_o));
   c_split: cover property (@(posedge core_clk_i) $rose(split_cycle_out_o));
   c_float: cover property (@(posedge core_clk_i) $rose(page_cache_disable_oe_n_o));
endmodule

// *** verification/cbas_chipset.sv ***
// ****
// chipset side of the host bus
// ****
module cbas_chipset (
   input wire logic core_clk_i,
   output logic strobe_n_o,
   output logic next_n_o,
   output logic ready_n_o,
   output logic last_o,
   output logic req_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {strobe_n_o, next_n_o, ready_n_o, last_o, req_n_o} = 5'h1D;
   end
   // one burst-ready that is not the last of the cycle
   task automatic beat();
      ready_n_o = 1'h0;
      @(negedge core_clk_i) ready_n_o = 1'h1;
   endtask
   // cycle start, returns once the strobe edge has passed
   task automatic start();
      @(negedge core_clk_i) strobe_n_o = 1'h0;
      @(negedge core_clk_i) strobe_n_o = 1'h1;
   endtask
   // end by next-address or by the last burst-ready
   task automatic fin(input logic by_next);
      if (by_next) next_n_o = 1'h0;
      else {ready_n_o, last_o} = 2'h1;
      @(negedge core_clk_i) {next_n_o, ready_n_o, last_o} = 3'h6;
   endtask
   // one-clock synchronous request
   task automatic mgmt_req();
      @(negedge core_clk_i) req_n_o = 1'h0;
      @(negedge core_clk_i) req_n_o = 1'h1;
   endtask
endmodule

// *** verification/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i, rst_i, next_address_in_n_i, back_off_in_n_i, bus_grant_ack_out_i, real_mode_i;
   logic cache_disable_bit_i, paging_enable_bit_i, locked_i, cyc_read_i, cyc_check_i, cache_flush_n_i;
   logic bus_idle_i, ext_write_buffer_empty_n_i, wbe_mask_i, boundary_i, mgmt_exit_i;
   logic address_strobe_n_i, burst_ready_in_n_i, last_ready_i, mgmt_interrupt_in_n_i;
   logic [1:0] page_base_reg_i, dir_entry_attr_i, tbl_entry_attr_i, attr_src_i;
   logic [3:0] xfer_size_i;
   logic [2:0] addr_low_i;
   logic [63:0] data_i;
   logic [7:0] data_par_i, byte_enables_n_i;
   logic page_cache_disable_out_o, page_cache_disable_oe_n_o, page_write_through_out_o;
   logic page_write_through_oe_n_o, split_cycle_out_o, split_cycle_oe_n_o, parity_error_out_n_o;
   logic parity_error_oe_n_o, mgmt_active_out_n_o, test_mode_o, mgmt_enter_o;
   logic [31:0] fetch_addr_o;
   int error_cnt = 0;
   int samples_checked = 0;
   // ****
   // design and chipset
   // ****
   cbas_core u_dut (.core_clk_i, .rst_i, .address_strobe_n_i, .next_address_in_n_i, .burst_ready_in_n_i,
      .last_ready_i, .back_off_in_n_i, .bus_grant_ack_out_i, .real_mode_i, .cache_disable_bit_i,
      .paging_enable_bit_i, .page_base_reg_i, .dir_entry_attr_i, .tbl_entry_attr_i, .attr_src_i, .locked_i,
      .xfer_size_i, .addr_low_i, .cyc_read_i, .cyc_check_i, .data_i, .data_par_i, .byte_enables_n_i,
      .cache_flush_n_i, .mgmt_interrupt_in_n_i, .bus_idle_i, .ext_write_buffer_empty_n_i, .wbe_mask_i,
      .boundary_i, .mgmt_exit_i, .page_cache_disable_out_o, .page_cache_disable_oe_n_o,
      .page_write_through_out_o, .page_write_through_oe_n_o, .split_cycle_out_o, .split_cycle_oe_n_o,
      .parity_error_out_n_o, .parity_error_oe_n_o, .mgmt_active_out_n_o, .test_mode_o, .fetch_addr_o,
      .mgmt_enter_o);
   cbas_chipset u_cs (.core_clk_i, .strobe_n_o(address_strobe_n_i), .next_n_o(next_address_in_n_i),
      .ready_n_o(burst_ready_in_n_i), .last_o(last_ready_i), .req_n_o(mgmt_interrupt_in_n_i));
   // ****
   // helpers
   // ****
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic pulse_bnd(input logic ex);
      @(negedge core_clk_i) {boundary_i, mgmt_exit_i} = {!ex, ex};
      @(negedge core_clk_i) {boundary_i, mgmt_exit_i} = 2'h0;
   endtask
   task automatic wait_act(input logic v);
      for (int i = 0; i < 20; i++) if (mgmt_active_out_n_o !== v) @(negedge core_clk_i);
      chk("active_n", mgmt_active_out_n_o, v);
   endtask
   // ****
   // scenarios
   // ****
   task automatic attr(input logic rmode, paged, cdis, input logic [1:0] src, input logic ep, ew, by_next);
      {real_mode_i, paging_enable_bit_i, cache_disable_bit_i, attr_src_i} = {rmode, paged, cdis, src};
      u_cs.start();
      chk("cache_dis", page_cache_disable_out_o, ep);
      chk("write_thru", page_write_through_out_o, ew);
      u_cs.beat();
      @(negedge core_clk_i);
      chk("attr_hold", {page_cache_disable_out_o, page_write_through_out_o}, {ep, ew});
      u_cs.fin(by_next);
      chk("attr_end", {page_cache_disable_out_o, page_write_through_out_o}, 2'h0);
   endtask
   task automatic par(input logic [7:0] en_n, input logic ck, input logic en);
      {cyc_read_i, cyc_check_i, byte_enables_n_i, data_par_i} = {1'h1, ck, en_n, 8'h04};
      u_cs.start();
      u_cs.fin(1'h0);
      chk("par_n", parity_error_out_n_o, en);
      @(negedge core_clk_i);
      chk("par_n_one", parity_error_out_n_o, 1'h1);
   endtask
   task automatic spl(input logic [3:0] sz, input logic [2:0] a, input logic e);
      {locked_i, xfer_size_i, addr_low_i} = {1'h1, sz, a};
      u_cs.start();
      chk("split", split_cycle_out_o, e);
      locked_i = 1'h0;
      u_cs.fin(1'h0);
      chk("split_end", split_cycle_out_o, 1'h0);
   endtask
   task automatic float_chk();
      u_cs.start();
      back_off_in_n_i = 1'h0;
      @(negedge core_clk_i) back_off_in_n_i = 1'h1;
      chk("oe_backoff", {page_cache_disable_oe_n_o, page_write_through_oe_n_o, split_cycle_oe_n_o}, 3'h7);
      u_cs.fin(1'h0);
      u_cs.start();
      chk("oe_on", {page_cache_disable_oe_n_o, page_write_through_oe_n_o, split_cycle_oe_n_o}, 3'h0);
      bus_grant_ack_out_i = 1'h1;
      @(negedge core_clk_i) bus_grant_ack_out_i = 1'h0;
      chk("oe_hold", {page_cache_disable_oe_n_o, page_write_through_oe_n_o, split_cycle_oe_n_o}, 3'h7);
      u_cs.fin(1'h0);
   endtask
   task automatic mgmt();
      u_cs.mgmt_req();
      pulse_bnd(1'h0);
      repeat (5) @(negedge core_clk_i);
      chk("act_wait_buf", mgmt_active_out_n_o, 1'h1);
      ext_write_buffer_empty_n_i = 1'h0;
      wait_act(1'h0);
      chk("enter", mgmt_enter_o, 1'h1);
      chk("entry", fetch_addr_o, cbas_pkg::CBAS_MGMT_BASE);
      u_cs.mgmt_req();
      pulse_bnd(1'h1);
      wait_act(1'h1);
      pulse_bnd(1'h0);
      wait_act(1'h0);
      chk("enter_again", mgmt_enter_o, 1'h1);
   endtask
   task automatic rst_chk(input logic fl);
      @(negedge core_clk_i) {rst_i, cache_flush_n_i} = {1'h1, fl};
      repeat (cbas_pkg::CBAS_WARM_RESET_CLKS) @(negedge core_clk_i);
      rst_i = 1'h0;
      @(negedge core_clk_i) cache_flush_n_i = 1'h1;
      chk("fetch", fetch_addr_o, cbas_pkg::CBAS_RESET_FETCH);
      chk("act_rst", mgmt_active_out_n_o, 1'h1);
      chk("test", {test_mode_o, parity_error_oe_n_o}, {!fl, !fl});
   endtask
   // ****
   // main sequence and watchdog
   // ****
   initial begin
      core_clk_i = 1'h0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   initial begin
      {rst_i, back_off_in_n_i, bus_grant_ack_out_i, real_mode_i, cache_disable_bit_i} = 5'h18;
      {paging_enable_bit_i, locked_i, cyc_read_i, cyc_check_i, cache_flush_n_i} = 5'h01;
      {bus_idle_i, ext_write_buffer_empty_n_i, wbe_mask_i, boundary_i, mgmt_exit_i} = 5'h18;
      {page_base_reg_i, dir_entry_attr_i, tbl_entry_attr_i} = 6'h27;
      {attr_src_i, xfer_size_i, addr_low_i, data_i} = '0;
      {data_par_i, byte_enables_n_i} = 16'h0000;
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'h0;
      attr(1'h1, 1'h1, 1'h1, 2'h0, 1'h1, 1'h0, 1'h0);
      attr(1'h0, 1'h0, 1'h0, 2'h0, 1'h0, 1'h0, 1'h1);
      attr(1'h0, 1'h1, 1'h0, 2'h0, 1'h1, 1'h0, 1'h0);
      attr(1'h0, 1'h1, 1'h0, 2'h1, 1'h0, 1'h1, 1'h1);
      attr(1'h0, 1'h1, 1'h0, 2'h2, 1'h1, 1'h1, 1'h0);
      par(8'hFB, 1'h1, 1'h0);
      par(8'h04, 1'h1, 1'h1);
      par(8'hFB, 1'h0, 1'h1);
      spl(4'h4, 3'h2, 1'h1);
      spl(4'h2, 3'h3, 1'h1);
      spl(4'h8, 3'h0, 1'h0);
      spl(4'h1, 3'h7, 1'h0);
      float_chk();
      mgmt();
      rst_chk(1'h1);
      rst_chk(1'h0);
      finish_test();
   end
   initial begin
      #50000;
      error_cnt++;
      finish_test();
   end
endmodule
